// *** logic/clkd_cfg.svh ***
`ifndef CLKD_CFG_SVH
`define CLKD_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define CLKD_OFF_BUS       4'h0
`define CLKD_OFF_PIX       4'h4

// ****************************************************************
// System-bus divider control fields
// ****************************************************************
`define CLKD_BUS_BUSY_BIT  29
`define CLKD_BUS_EN_HI     28
`define CLKD_BUS_EN_LO     21
`define CLKD_BUS_CONG_IDX  3
`define CLKD_BUS_AUTO_BIT  20
`define CLKD_BUS_SLOW_HI   18
`define CLKD_BUS_SLOW_LO   16
`define CLKD_BUS_FRAC_BIT  5
`define CLKD_BUS_DIV_HI    4
`define CLKD_BUS_DIV_LO    0
`define CLKD_BUS_DIV_RST   5'h01

// ****************************************************************
// Pixel divider control fields
// ****************************************************************
`define CLKD_PIX_GATE_BIT  31
`define CLKD_PIX_BUSY_BIT  29
`define CLKD_PIX_FRAC_BIT  12
`define CLKD_PIX_DIV_HI    11
`define CLKD_PIX_DIV_LO    0
`define CLKD_PIX_DIV_RST   12'h001
`define CLKD_PIX_GATE_RST  1'b1

// ****************************************************************
// Timing counts
// ****************************************************************
`define CLKD_CONG_MASTERS  8'h03
`define CLKD_BUSY_MAX      6'h21
`define CLKD_PIX_BUSY_MAX  9'h100

`endif

// *** logic/clkd_pkg.sv ***
`default_nettype none

package clkd_pkg;

  // Slow-mode divide codes
  typedef enum logic [2:0] {
    CLKD_SLOW_BY1  = 3'h0,
    CLKD_SLOW_BY2  = 3'h1,
    CLKD_SLOW_BY4  = 3'h2,
    CLKD_SLOW_BY8  = 3'h3,
    CLKD_SLOW_BY16 = 3'h4,
    CLKD_SLOW_BY32 = 3'h5
  } clkd_slow_code_t;

  typedef logic [4:0]  clkd_bus_ratio_t;
  typedef logic [11:0] clkd_pix_ratio_t;

endpackage

`default_nettype wire

// *** logic/clkd_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Link between control registers and one divider
// ****************************************************************
interface clkd_div_if #(parameter int W = 5);
  logic [W-1:0] ratio;
  logic         fracEn;
  logic         load;
  logic         run;
  logic         slow;
  logic [2:0]   slowCode;
  logic         busy;
  logic         tick;

  modport ctrl (output ratio, fracEn, load, run, slow, slowCode,
                input busy, tick);
  modport div  (input ratio, fracEn, load, run, slow, slowCode,
                output busy, tick);
endinterface

`default_nettype wire

// *** logic/clkd_divider.sv ***
`timescale 1ns/1ps
`default_nettype none

module clkd_divider #(
  parameter int W      = 5,
  parameter bit FRAC_OK = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control side
  clkd_div_if.div  d
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [W-1:0] ratioReg, pendRatio, cntReg, accReg;
  logic         fracReg, pendFrac, pendReg, tickReg;
  logic [4:0]   slowCntReg;

  // Counters and accumulator are sized by W; outside this span they break
  if (W < 2 || W > 16) begin : g_bad_width
    $error("W must lie in 2..16");
  end

  // Slow code to tick mask; codes above the top code clamp to it
  function automatic logic [4:0] slowMask(input logic [2:0] code);
    logic [2:0] c;
    c = (code > 3'h5) ? 3'h5 : code;
    slowMask = 5'(6'h3f >> (3'h6 - c)) & 5'h1f;
    if (c == 3'h0) slowMask = 5'h00;
  endfunction

  // ****************************************************************
  // Period decode
  // ****************************************************************
  // A zero ratio would never end a period, so it behaves as one
  wire [W-1:0] effRatio = (ratioReg == '0) ? W'(1) : ratioReg;
  wire [W:0]   accSum   = {1'b0, accReg} + {1'b0, effRatio};
  wire         baseTick = fracReg ? accSum[W]
                                  : (cntReg == effRatio - W'(1));
  wire         slowDone = !d.slow || (slowCntReg == slowMask(d.slowCode));
  // New ratio lands at a period edge, or at once while stopped
  wire         apply    = pendReg && (baseTick || !d.run);

  assign d.busy = pendReg;
  assign d.tick = tickReg;

  // ****************************************************************
  // Ratio hand-over
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pendReg   <= 1'b0;
      pendRatio <= W'(1);
      pendFrac  <= 1'b0;
    end else if (d.load) begin
      pendReg   <= 1'b1;
      pendRatio <= d.ratio;
      pendFrac  <= d.fracEn & FRAC_OK;
    end else if (apply) begin
      pendReg   <= 1'b0;
    end
  end

  // ****************************************************************
  // Counters and output tick
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ratioReg <= W'(1);
      fracReg  <= 1'b0;
      cntReg   <= '0;
      accReg   <= '0;
    end else if (apply && !d.load) begin
      ratioReg <= pendRatio;
      fracReg  <= pendFrac;
      cntReg   <= '0;
      accReg   <= '0;
    end else if (d.run) begin
      cntReg   <= baseTick ? '0 : cntReg + W'(1);
      accReg   <= accSum[W-1:0];
    end
  end

  // Slow prescale on top of the base ratio
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slowCntReg <= 5'h00;
      tickReg    <= 1'b0;
    end else begin
      tickReg <= d.run && baseTick && slowDone;
      if (d.run && baseTick) slowCntReg <= slowDone ? 5'h00
                                          : slowCntReg + 5'h01;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_int_count_range:
  assert property (@(posedge clk_sys) disable iff (rst)
    !fracReg |-> cntReg < effRatio)
    else $error("integer count beyond ratio");

  a_slow_tick_gap:
  assert property (@(posedge clk_sys) disable iff (rst)
    tickReg && d.slow && d.slowCode != 3'h0 && $stable(d.slowCode)
      |=> !tickReg)
    else $error("slow tick too close");

endmodule

`default_nettype wire

// *** logic/clkd_top.sv ***
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "clkd_cfg.svh"
// Operation
// - Each divider's busy flag is high while a new ratio is pending.
// - Auto-slow bit makes the bus clock slow until an enabled event.
// - Per-source enables let activity restore full bus rate.
// - Congestion enable slows while fewer than three masters request.
// - Slow code 0..5 divides the bus rate by 1,2,4,8,16,32.
// - Fractional-enable bit picks fractional or integer bus division.
// - Bus ratio divides the clock; resets to one; zero is illegal.
// - Bus divider runs only while memory sync mode is off.
// - Pixel stop bit resets high; high stops, low runs pixel clock.
// - Pixel ratio divides reference; resets to one; 1..255 legal.

module clkd_top #(
  parameter int NUM_MASTERS = 8
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Register port
  input  wire logic [3:0]             regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regWrStrobe,
  input  wire logic                   regRdStrobe,
  output logic      [31:0]            regRdData,
  // Activity sources
  input  wire logic                   coprocActive,
  input  wire logic                   pixelPipeActive,
  input  wire logic                   hdmaActive,
  input  wire logic                   xdmaActive,
  input  wire logic                   masterActive,
  input  wire logic                   cpuDataActive,
  input  wire logic                   cpuFetchActive,
  input  wire logic [NUM_MASTERS-1:0] masterReq,
  // Memory sync mode
  input  wire logic                   memSyncModeEnable,
  // Divided clock enables and bus slow status
  output logic                        busClkTick,
  output logic                        pixClkTick,
  output logic                        busSlowActive
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_MASTERS < 3 || NUM_MASTERS > 255) begin : g_bad_masters
    $error("NUM_MASTERS must lie in 3..255");
  end

  // Count of requesting masters
  function automatic logic [7:0] countOnes(
    input logic [NUM_MASTERS-1:0] v);
    countOnes = 8'h00;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      countOnes = countOnes + {7'h00, v[i]};
    end
  endfunction

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0]                     slowEnReg;
  logic                           autoSlowReg;
  clkd_pkg::clkd_slow_code_t      slowCodeReg;
  logic                           busFracReg;
  clkd_pkg::clkd_bus_ratio_t      busRatioReg;
  logic                           pixGateReg;
  logic                           pixFracReg;
  clkd_pkg::clkd_pix_ratio_t      pixRatioReg;
  logic                           slowReg;
  logic [31:0]                    rdDataReg;
  logic [31:0]                    rdData_next;
  logic [5:0]                     busyAgeReg;
  logic [8:0]                     pixAgeReg;

  clkd_div_if #(.W(5))  busDiv ();
  clkd_div_if #(.W(12)) pixDiv ();

  // Address decode
  wire busSel   = (regAddr == `CLKD_OFF_BUS);
  wire pixSel   = (regAddr == `CLKD_OFF_PIX);
  wire busWrite = regWrStrobe && busSel;
  wire pixWrite = regWrStrobe && pixSel;

  // Register writes; the block trusts software to wait out busy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slowEnReg   <= 8'h00;
      autoSlowReg <= 1'b0;
      slowCodeReg <= clkd_pkg::CLKD_SLOW_BY1;
      busFracReg  <= 1'b0;
      busRatioReg <= `CLKD_BUS_DIV_RST;
    end else if (busWrite) begin
      slowEnReg   <= regWrData[`CLKD_BUS_EN_HI:`CLKD_BUS_EN_LO];
      autoSlowReg <= regWrData[`CLKD_BUS_AUTO_BIT];
      slowCodeReg <= clkd_pkg::clkd_slow_code_t'(
                       regWrData[`CLKD_BUS_SLOW_HI:`CLKD_BUS_SLOW_LO]);
      busFracReg  <= regWrData[`CLKD_BUS_FRAC_BIT];
      busRatioReg <= regWrData[`CLKD_BUS_DIV_HI:`CLKD_BUS_DIV_LO];
    end
  end

  // Pixel control; fractional bit is stored and read back but never used for division
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pixGateReg  <= `CLKD_PIX_GATE_RST;
      pixFracReg  <= 1'b0;
      pixRatioReg <= `CLKD_PIX_DIV_RST;
    end else if (pixWrite) begin
      pixGateReg  <= regWrData[`CLKD_PIX_GATE_BIT];
      pixFracReg  <= regWrData[`CLKD_PIX_FRAC_BIT];
      pixRatioReg <= regWrData[`CLKD_PIX_DIV_HI:`CLKD_PIX_DIV_LO];
    end
  end

  // ****************************************************************
  // Auto-slow decision
  // ****************************************************************
  // Sources in enable order, with the congestion slot left out
  wire [6:0] actVec   = {coprocActive, pixelPipeActive, hdmaActive,
                         xdmaActive, masterActive, cpuDataActive,
                         cpuFetchActive};
  wire [6:0] actEn    = {slowEnReg[7:4], slowEnReg[2:0]};
  wire       congEn   = slowEnReg[`CLKD_BUS_CONG_IDX];
  wire [7:0] reqCount = countOnes(masterReq);
  wire       congBusy = congEn && (reqCount >= `CLKD_CONG_MASTERS);
  wire       fastReq  = (|(actVec & actEn)) || congBusy;
  wire       slow_next = autoSlowReg && !fastReq;

  // Registered so the divider sees a clean level
  always_ff @(posedge clk_sys) begin
    if (rst) slowReg <= 1'b0;
    else     slowReg <= slow_next;
  end

  // ****************************************************************
  // Divider hookup
  // ****************************************************************
  assign busDiv.ratio    = regWrData[`CLKD_BUS_DIV_HI:`CLKD_BUS_DIV_LO];
  assign busDiv.fracEn   = regWrData[`CLKD_BUS_FRAC_BIT];
  assign busDiv.load     = busWrite;
  assign busDiv.run      = !memSyncModeEnable;
  assign busDiv.slow     = slowReg;
  assign busDiv.slowCode = slowCodeReg;

  assign pixDiv.ratio    = regWrData[`CLKD_PIX_DIV_HI:`CLKD_PIX_DIV_LO];
  assign pixDiv.fracEn   = 1'b0;
  assign pixDiv.load     = pixWrite;
  assign pixDiv.run      = !pixGateReg;
  assign pixDiv.slow     = 1'b0;
  assign pixDiv.slowCode = 3'h0;

  clkd_divider #(.W(5), .FRAC_OK(1'b1)) u_bus_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (busDiv)
  );

  clkd_divider #(.W(12), .FRAC_OK(1'b0)) u_pix_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (pixDiv)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [31:0] busView = {2'h0, busDiv.busy, slowEnReg, autoSlowReg,
                         1'b0, slowCodeReg, 10'h000, busFracReg,
                         busRatioReg};
  wire [31:0] pixView = {pixGateReg, 1'b0, pixDiv.busy, 16'h0000,
                         pixFracReg, pixRatioReg};

  // Unmapped reads answer zero
  always_comb begin
    rdData_next = 32'h0000_0000;
    if (regRdStrobe && busSel) rdData_next = busView;
    if (regRdStrobe && pixSel) rdData_next = pixView;
  end

  // Data stand for the single cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) rdDataReg <= 32'h0000_0000;
    else     rdDataReg <= rdData_next;
  end

  assign regRdData     = rdDataReg;
  assign busClkTick    = busDiv.tick;
  assign pixClkTick    = pixDiv.tick;
  assign busSlowActive = slowReg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Age of a pending bus ratio while the divider runs
  always_ff @(posedge clk_sys) begin
    if (rst || !busDiv.busy || busWrite || !busDiv.run)
      busyAgeReg <= 6'h00;
    else if (busyAgeReg != 6'h3f)
      busyAgeReg <= busyAgeReg + 6'h01;
  end

  // Age of a pending pixel ratio; a stopped divider applies at once
  always_ff @(posedge clk_sys) begin
    if (rst || !pixDiv.busy || pixWrite || !pixDiv.run)
      pixAgeReg <= 9'h000;
    else if (pixAgeReg != 9'h1ff)
      pixAgeReg <= pixAgeReg + 9'h001;
  end

  a_pix_busy_bound:
  assert property (@(posedge clk_sys) disable iff (rst)
    pixAgeReg <= `CLKD_PIX_BUSY_MAX)
    else $error("pixel busy held too long");

  a_pix_readback:
  assert property (@(posedge clk_sys) disable iff (rst)
    regRdStrobe && pixSel |=>
      regRdData[`CLKD_PIX_BUSY_BIT] == $past(pixDiv.busy))
    else $error("pixel busy bit misreported");

  a_bus_busy_quiet:
  assert property (@(posedge clk_sys) disable iff (rst)
    !busDiv.busy && !busWrite |=> !busDiv.busy)
    else $error("bus busy raised without a write");

  a_pix_busy_quiet:
  assert property (@(posedge clk_sys) disable iff (rst)
    !pixDiv.busy && !pixWrite |=> !pixDiv.busy)
    else $error("pixel busy raised without a write");

  a_auto_slow_off:
  assert property (@(posedge clk_sys) disable iff (rst)
    !autoSlowReg |=> !busSlowActive)
    else $error("bus slow without auto-slow");

  a_pix_ratio_read:
  assert property (@(posedge clk_sys) disable iff (rst)
    regRdStrobe && pixSel |=>
      regRdData[`CLKD_PIX_DIV_HI:`CLKD_PIX_DIV_LO] == $past(pixRatioReg))
    else $error("pixel ratio misreported");

  a_bus_busy_rise:
  assert property (@(posedge clk_sys) disable iff (rst)
    busWrite |=> busDiv.busy)
    else $error("bus busy not raised after write");

  a_pix_busy_rise:
  assert property (@(posedge clk_sys) disable iff (rst)
    pixWrite |=> pixDiv.busy)
    else $error("pixel busy not raised after write");

  a_bus_busy_bound:
  assert property (@(posedge clk_sys) disable iff (rst)
    busyAgeReg <= `CLKD_BUSY_MAX)
    else $error("bus busy held too long");

  a_busy_readback:
  assert property (@(posedge clk_sys) disable iff (rst)
    regRdStrobe && busSel |=>
      regRdData[`CLKD_BUS_BUSY_BIT] == $past(busDiv.busy))
    else $error("busy bit misreported");

  a_mem_sync_stop:
  assert property (@(posedge clk_sys) disable iff (rst)
    memSyncModeEnable ##1 memSyncModeEnable |-> !busClkTick)
    else $error("bus tick while memory sync mode");

  a_pix_gate_stop:
  assert property (@(posedge clk_sys) disable iff (rst)
    pixGateReg ##1 pixGateReg |-> !pixClkTick)
    else $error("pixel tick while stopped");

  a_auto_slow_on:
  assert property (@(posedge clk_sys) disable iff (rst)
    autoSlowReg && !fastReq |=> busSlowActive)
    else $error("auto-slow did not engage");

  a_event_fast:
  assert property (@(posedge clk_sys) disable iff (rst)
    (|(actVec & actEn)) |=> !busSlowActive)
    else $error("enabled event left bus slow");

  a_congestion_fast:
  assert property (@(posedge clk_sys) disable iff (rst)
    congEn && reqCount >= 8'h03 |=> !busSlowActive)
    else $error("three masters left bus slow");

  a_reset_ratio:
  assert property (@(posedge clk_sys)
    $past(rst) |-> busRatioReg == 5'h01 && pixRatioReg == 12'h001)
    else $error("ratio reset value wrong");

  a_reset_gate:
  assert property (@(posedge clk_sys)
    $past(rst) |-> pixGateReg && !busSlowActive)
    else $error("pixel stop reset value wrong");

endmodule

`default_nettype wire

// *** tb/clkd_fabric_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Far side: activity sources and consumers of the divided clocks
// ****************************************************************
module clkd_fabric_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Commands from the bench
  input  wire logic [6:0]  actCmd,
  input  wire logic [7:0]  reqCmd,
  input  wire logic        cntClr,
  // Divided clock enables
  input  wire logic        busClkTick,
  input  wire logic        pixClkTick,
  // Activity toward the block
  output logic      [6:0]  actOut,
  output logic      [7:0]  masterReq,
  // Observed tick counts
  output logic      [15:0] busCount,
  output logic      [15:0] pixCount
);
  // Sources change only after an edge, as real requesters do
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      actOut    <= 7'h00;
      masterReq <= 8'h00;
    end else begin
      actOut    <= actCmd;
      masterReq <= reqCmd;
    end
  end

  // Consumers count the enables they see; clear restarts a window
  always_ff @(posedge clk_sys) begin
    if (rst || cntClr) begin
      busCount <= 16'h0000;
      pixCount <= 16'h0000;
    end else begin
      busCount <= busCount + 16'(busClkTick);
      pixCount <= pixCount + 16'(pixClkTick);
    end
  end
endmodule

`default_nettype wire

// *** tb/test_ahb_and_pixel_clock_dividers.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clkd_cfg.svh"

module test_ahb_and_pixel_clock_dividers;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_sys, rst, regWrStrobe, regRdStrobe, cntClr;
  logic        memSyncModeEnable, busClkTick, pixClkTick, busSlowActive;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData, rd;
  logic [6:0]  actCmd, act;
  logic [7:0]  reqCmd, masterReq;
  logic [15:0] busCount, pixCount;
  int          mismatches, check_count, cycles;
  int          enBit [7] = '{28, 27, 26, 25, 23, 22, 21};
  int          ratios [3] = '{2, 5, 31};
  logic [7:0]  reqs [4] = '{8'h03, 8'h07, 8'h0f, 8'h00};
  logic        slowExp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  clkd_top #(.NUM_MASTERS(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .coprocActive(act[0]), .pixelPipeActive(act[1]),
    .hdmaActive(act[2]), .xdmaActive(act[3]), .masterActive(act[4]),
    .cpuDataActive(act[5]), .cpuFetchActive(act[6]),
    .masterReq(masterReq), .memSyncModeEnable(memSyncModeEnable),
    .busClkTick(busClkTick), .pixClkTick(pixClkTick),
    .busSlowActive(busSlowActive));

  clkd_fabric_model fab (
    .clk_sys(clk_sys), .rst(rst), .actCmd(actCmd), .reqCmd(reqCmd),
    .cntClr(cntClr), .busClkTick(busClkTick), .pixClkTick(pixClkTick),
    .actOut(act), .masterReq(masterReq), .busCount(busCount),
    .pixCount(pixCount));

  // ****************************************************************
  // Compare and access tasks
  // ****************************************************************
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkCnt(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk_sys);
    regWrStrobe <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk_sys);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Bounded poll; a slow pixel period can hold busy a few hundred cycles
  task automatic waitIdle(input logic [3:0] a);
    int          n;
    logic [31:0] d;
    n = 0;
    do begin
      regRead(a, d);
      n++;
    end while (d[29] !== 1'b0 && n < 200);
    chkBit(d[29], 1'b0);
  endtask

  task automatic wrIdle(input logic [3:0] a, input logic [31:0] d);
    regWrite(a, d);
    waitIdle(a);
  endtask

  task automatic countTicks(input int n, input logic [15:0] eb,
                            input logic [15:0] ep);
    @(posedge clk_sys);
    cntClr <= 1'b1;
    @(posedge clk_sys);
    cntClr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    chkCnt(busCount, eb);
    chkCnt(pixCount, ep);
  endtask

  task automatic drive(input logic [6:0] a, input logic [7:0] r);
    @(posedge clk_sys);
    actCmd <= a;
    reqCmd <= r;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1; regAddr = 4'h0; regWrData = 32'h0; regWrStrobe = 1'b0;
    regRdStrobe = 1'b0; cntClr = 1'b0; memSyncModeEnable = 1'b0;
    actCmd = 7'h00; reqCmd = 8'h00; mismatches = 0; check_count = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    regRead(`CLKD_OFF_BUS, rd); chkReg(rd, 32'h0000_0001);
    regRead(`CLKD_OFF_PIX, rd); chkReg(rd, 32'h8000_0001);
    regRead(4'h8, rd); chkReg(rd, 32'h0000_0000);
    countTicks(20, 16'd20, 16'd0);
    @(posedge clk_sys);
    memSyncModeEnable <= 1'b1;
    countTicks(20, 16'd0, 16'd0);
    @(posedge clk_sys);
    memSyncModeEnable <= 1'b0;
    // Integer ratios up to the field maximum
    foreach (ratios[i]) begin
      wrIdle(`CLKD_OFF_BUS, 32'(ratios[i]));
      countTicks(4 * ratios[i], 16'd4, 16'd0);
    end
    // Busy seen while the long period is still running
    regWrite(`CLKD_OFF_BUS, 32'h0000_0028);
    regRead(`CLKD_OFF_BUS, rd); chkReg(rd, 32'h2000_0028);
    waitIdle(`CLKD_OFF_BUS);
    countTicks(64, 16'd16, 16'd0);
    wrIdle(`CLKD_OFF_BUS, 32'h0000_0030);
    countTicks(64, 16'd32, 16'd0);
    wrIdle(`CLKD_OFF_BUS, 32'hffef_ffff);
    regRead(`CLKD_OFF_BUS, rd); chkReg(rd, 32'h1fe7_003f);
    // Slow codes: auto-slow off before each new code
    for (int c = 0; c < 6; c++) begin
      wrIdle(`CLKD_OFF_BUS, (32'(c) << 16) | 32'h1);
      wrIdle(`CLKD_OFF_BUS, (32'(c) << 16) | 32'h0010_0001);
      countTicks(64, 16'(64 >> c), 16'd0);
      chkBit(busSlowActive, 1'b1);
      wrIdle(`CLKD_OFF_BUS, (32'(c) << 16) | 32'h1);
    end
    wrIdle(`CLKD_OFF_BUS, 32'h0000_0001);
    // Each source restores full rate only when its enable is set
    for (int i = 0; i < 7; i++) begin
      wrIdle(`CLKD_OFF_BUS, 32'h0010_0001 | (32'h1 << enBit[i]));
      drive(~(7'h01 << i), 8'h00); chkBit(busSlowActive, 1'b1);
      drive(7'h01 << i, 8'h00); chkBit(busSlowActive, 1'b0);
      drive(7'h00, 8'h00); chkBit(busSlowActive, 1'b1);
    end
    // Congestion: slow below three requesting masters
    wrIdle(`CLKD_OFF_BUS, 32'h0110_0001);
    foreach (reqs[i]) begin
      drive(7'h00, reqs[i]); chkBit(busSlowActive, slowExp[i]);
    end
    wrIdle(`CLKD_OFF_BUS, 32'h0000_0001);
    // Pixel divider: start, ratio change while running, stop
    wrIdle(`CLKD_OFF_PIX, 32'h0000_0001);
    countTicks(10, 16'd10, 16'd10);
    wrIdle(`CLKD_OFF_PIX, 32'h7fff_e0ff);
    regRead(`CLKD_OFF_PIX, rd); chkReg(rd, 32'h0000_00ff);
    countTicks(510, 16'd510, 16'd2);
    regWrite(`CLKD_OFF_PIX, 32'h0000_0003);
    regRead(`CLKD_OFF_PIX, rd); chkReg(rd, 32'h2000_0003);
    waitIdle(`CLKD_OFF_PIX);
    countTicks(30, 16'd30, 16'd10);
    wrIdle(`CLKD_OFF_PIX, 32'h8000_0003);
    countTicks(30, 16'd30, 16'd0);
    end_of_test();
  end
endmodule

`default_nettype wire
